// ---- core/rtcca_params.svh ----
`ifndef RTCCA_PARAMS_SVH
`define RTCCA_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RTCCA_OFS_SEC 8'h00
`define RTCCA_OFS_DAY 8'h04
`define RTCCA_OFS_ASEC 8'h08
`define RTCCA_OFS_ADAY 8'h0C
`define RTCCA_OFS_CTRL 8'h10
`define RTCCA_OFS_CHG 8'h14
`define RTCCA_OFS_FLAG 8'h18
`define RTCCA_OFS_MASK 8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RTCCA_CTRL_OFF 0
`define RTCCA_CTRL_POL_LO 1
`define RTCCA_CTRL_TRIM_LO 4
`define RTCCA_CHG_LVL_LO 1
`define RTCCA_FLG_TICK 0
`define RTCCA_FLG_ALARM 1
`define RTCCA_FLG_LOST 2

// ----------------------------------------------------------------
// counts and reset values
// ----------------------------------------------------------------
`define RTCCA_DIV_NOM 17'h08000
`define RTCCA_SEC_MAX 17'h1517F
`define RTCCA_POL_OFF 2'h0
`define RTCCA_POL_MAIN 2'h1
`define RTCCA_POL_RSVD 2'h2
`define RTCCA_POL_ALL 2'h3
`define RTCCA_MASK_RST 3'h7
`define RTCCA_FLAG_RST 3'h4

`endif

// ---- core/rtcca_pkg.sv ----
package rtcca_pkg;

   // backup charger control toward the analog cell
   typedef struct packed {
      logic connect;    // cell joined to internal circuits
      logic on;         // charger enabled
      logic [2:0] level; // target voltage code
      logic cur_high;   // high charge current
      logic cur_low;    // low charge current
   } rtcca_chg_t;

   // synchronised pin levels
   typedef struct packed {
      logic uv;
      logic coin_only;
      logic sys_on;
      logic osc;
   } rtcca_pins_t;

endpackage

// ---- core/rtcca_top.sv ----
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "rtcca_params.svh"

// Overview of operation
// - oscillator divided to tick; seconds advance
// - seconds wrap to zero after 86399
// - wrap increments 15-bit day counter
// - tick sets flag; interrupt when unmasked
// - alarm flag on seconds and day match
// - alarm wakes when off, interrupts when on
// - clock-off bit stops timekeeping; resets 0
// - backup reset clears backed registers except masks and lost flag, which it sets
// - backup reset sets timekeeping-lost flag
// - signed 5-bit word trims divider
// - trim value is counts per second
// - clock output unaffected by trim
// - policy 00 off, 01 main, 11 always
// - cell connects only on power-on
// - charger enable bit and 3-bit level
// - high current on, low when off
// - undervoltage stops charging
// - charger enable cleared only by reset or a write of zero
// - flags latch until written one
// - masks reset set; unmask raises interrupt
module rtcca_top (
   // clock and backup-domain reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins from outside
   input wire logic osc_i,
   input wire logic sys_on_i,
   input wire logic coin_only_i,
   input wire logic undervoltage_limit_i,
   // outputs
   output logic irq_o,
   output logic wake_o,
   output logic slow_clock_out_o,
   output rtcca_pkg::rtcca_chg_t charge_o
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   rtcca_pkg::rtcca_pins_t sync1_q; // first stage, read only by second
   rtcca_pkg::rtcca_pins_t pins_q;  // synchronised levels
   logic osc_prev_q;               // for edge detection
   logic osc_rise;
   logic [16:0] div_cnt_q;         // oscillator edges this second
   logic [16:0] term_cnt;          // divider terminal count
   logic trim_on;
   logic tick;
   logic tick_dly_q;               // tick one cycle late, for alarm
   logic [16:0] seconds_in_day_counter_q;
   logic [14:0] day_q;
   logic [16:0] alarm_seconds_q;
   logic [14:0] alarm_day_q;
   logic clock_off_bit_q;
   logic [1:0] drift_trim_policy_q;
   logic [4:0] drift_trim_word_q;
   logic backup_charge_on_q;
   logic [2:0] backup_charge_level_q;
   logic cell_connect_q;
   logic [2:0] flags_q;            // lost, alarm, tick
   logic [2:0] flags_set;
   logic [2:0] flags_clr;
   logic [2:0] mask_q;
   logic alarm_ev;
   logic wake_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic req;
   logic wr;
   logic [7:0] ofs;

   // byte-lane merge of a write into an old value
   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] dat, input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge = (old & ~m) | (dat & m);
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // two stages before any logic looks at a pin
   always_ff @(posedge clk_i) begin
      sync1_q <= {undervoltage_limit_i, coin_only_i, sys_on_i, osc_i};
      pins_q <= sync1_q;
      osc_prev_q <= pins_q.osc;
   end

   assign osc_rise = pins_q.osc & ~osc_prev_q;
   // clock out follows the oscillator, untouched by trim
   assign slow_clock_out_o = pins_q.osc;

   // ----------------------------------------------------------------
   // one-second divider
   // ----------------------------------------------------------------
   // trim allowed by policy; reserved code acts as disabled
   assign trim_on = (drift_trim_policy_q == `RTCCA_POL_ALL) ||
         ((drift_trim_policy_q == `RTCCA_POL_MAIN) && !pins_q.coin_only);
   // signed trim added to the nominal period
   assign term_cnt = `RTCCA_DIV_NOM - 17'h00001 +
         (trim_on ? {{12{drift_trim_word_q[4]}}, drift_trim_word_q} : 17'h00000);
   assign tick = osc_rise && !clock_off_bit_q && (div_cnt_q == term_cnt);

   // counts oscillator edges, held at zero while the clock is off
   always_ff @(posedge clk_i) begin
      if (rst_i || clock_off_bit_q) begin
         div_cnt_q <= 17'h00000;
      end else if (tick) begin
         div_cnt_q <= 17'h00000;
      end else if (osc_rise) begin
         div_cnt_q <= div_cnt_q + 17'h00001;
      end
   end

   // ----------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------
   assign req = wb_cyc_i && wb_stb_i;
   assign wr = req && wb_we_i && ack_q; // write lands on the ack edge
   assign ofs = wb_adr_i[7:0];

   // one wait state, ack dropped after one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req && !ack_q;
      end
   end

   // read data captured in the cycle before ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h00000000;
      end else if (req && !ack_q) begin
         case (ofs)
            `RTCCA_OFS_SEC: rdat_q <= {15'h0000, seconds_in_day_counter_q};
            `RTCCA_OFS_DAY: rdat_q <= {17'h00000, day_q};
            `RTCCA_OFS_ASEC: rdat_q <= {15'h0000, alarm_seconds_q};
            `RTCCA_OFS_ADAY: rdat_q <= {17'h00000, alarm_day_q};
            `RTCCA_OFS_CTRL: rdat_q <= {23'h000000, drift_trim_word_q, 1'b0,
                  drift_trim_policy_q, clock_off_bit_q};
            `RTCCA_OFS_CHG: rdat_q <= {27'h0000000, cell_connect_q,
                  backup_charge_level_q, backup_charge_on_q};
            `RTCCA_OFS_FLAG: rdat_q <= {29'h00000000, flags_q};
            `RTCCA_OFS_MASK: rdat_q <= {29'h00000000, mask_q};
            default: rdat_q <= 32'h00000000; // unmapped reads zero
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ----------------------------------------------------------------
   // time and day counters
   // ----------------------------------------------------------------
   // software write beats a tick in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seconds_in_day_counter_q <= 17'h00000;
      end else if (wr && ofs == `RTCCA_OFS_SEC) begin
         seconds_in_day_counter_q <= 17'(merge({15'h0000, seconds_in_day_counter_q},
               wb_dat_i, wb_sel_i));
      end else if (tick && seconds_in_day_counter_q == `RTCCA_SEC_MAX) begin
         seconds_in_day_counter_q <= 17'h00000;
      end else if (tick) begin
         seconds_in_day_counter_q <= seconds_in_day_counter_q + 17'h00001;
      end
   end

   // day counter advances on each wrap
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         day_q <= 15'h0000;
      end else if (wr && ofs == `RTCCA_OFS_DAY) begin
         day_q <= 15'(merge({17'h00000, day_q}, wb_dat_i, wb_sel_i));
      end else if (tick && seconds_in_day_counter_q == `RTCCA_SEC_MAX) begin
         day_q <= day_q + 15'h0001;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // alarm compare values
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alarm_seconds_q <= 17'h00000;
         alarm_day_q <= 15'h0000;
      end else begin
         if (wr && ofs == `RTCCA_OFS_ASEC) begin
            alarm_seconds_q <= 17'(merge({15'h0000, alarm_seconds_q}, wb_dat_i, wb_sel_i));
         end
         if (wr && ofs == `RTCCA_OFS_ADAY) begin
            alarm_day_q <= 15'(merge({17'h00000, alarm_day_q}, wb_dat_i, wb_sel_i));
         end
      end
   end

   // clock-off, trim policy and trim word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_off_bit_q <= 1'b0;
         drift_trim_policy_q <= `RTCCA_POL_OFF;
         drift_trim_word_q <= 5'h00;
      end else if (wr && ofs == `RTCCA_OFS_CTRL && wb_sel_i[0]) begin
         clock_off_bit_q <= wb_dat_i[`RTCCA_CTRL_OFF];
         drift_trim_policy_q <= wb_dat_i[`RTCCA_CTRL_POL_LO +: 2];
         drift_trim_word_q <= wb_dat_i[`RTCCA_CTRL_TRIM_LO +: 5];
      end
   end

   // charger settings; enable cleared only by the backup reset or a write of zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         backup_charge_on_q <= 1'b0;
         backup_charge_level_q <= 3'h0;
      end else if (wr && ofs == `RTCCA_OFS_CHG && wb_sel_i[0]) begin
         backup_charge_on_q <= wb_dat_i[0];
         backup_charge_level_q <= wb_dat_i[`RTCCA_CHG_LVL_LO +: 3];
      end
   end

   // cell joins once the system is on (covers charger enable while on)
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cell_connect_q <= 1'b0;
      end else if (pins_q.sys_on) begin
         cell_connect_q <= 1'b1;
      end
   end

   // charger drive, current picked by system state
   always_comb begin
      charge_o.connect = cell_connect_q;
      charge_o.on = backup_charge_on_q && cell_connect_q && !pins_q.uv;
      charge_o.level = backup_charge_level_q;
      charge_o.cur_high = charge_o.on && pins_q.sys_on;
      charge_o.cur_low = charge_o.on && !pins_q.sys_on;
   end

   // ----------------------------------------------------------------
   // events, masks and interrupt
   // ----------------------------------------------------------------
   // alarm compared against counters just after they advance
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_dly_q <= 1'b0;
      end else begin
         tick_dly_q <= tick;
      end
   end

   assign alarm_ev = tick_dly_q && (seconds_in_day_counter_q == alarm_seconds_q) &&
         (day_q == alarm_day_q);

   assign flags_set = {1'b0, alarm_ev, tick};
   assign flags_clr = (wr && ofs == `RTCCA_OFS_FLAG && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;

   // sticky flags; a set in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_q <= `RTCCA_FLAG_RST;
      end else begin
         flags_q <= (flags_q & ~flags_clr) | flags_set;
      end
   end

   // masks start fully masked
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= `RTCCA_MASK_RST;
      end else if (wr && ofs == `RTCCA_OFS_MASK && wb_sel_i[0]) begin
         mask_q <= wb_dat_i[2:0];
      end
   end

   // wake pulse for an alarm while the system is off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= alarm_ev && !pins_q.sys_on;
      end
   end

   assign wake_o = wake_q;
   // interrupt only reaches the processor while on
   assign irq_o = |(flags_q & ~mask_q) && pins_q.sys_on;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_sec_inc;
      tick && !wr && seconds_in_day_counter_q != `RTCCA_SEC_MAX
         |=> seconds_in_day_counter_q == $past(seconds_in_day_counter_q) + 17'h00001;
   endproperty
   a_sec_inc: assert property (p_sec_inc) else $error("seconds did not advance");

   property p_wrap;
      tick && !wr && seconds_in_day_counter_q == `RTCCA_SEC_MAX
         |=> seconds_in_day_counter_q == 17'h00000 && day_q == $past(day_q) + 15'h0001;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap or day increment wrong");

   property p_tick_flag;
      tick |=> flags_q[`RTCCA_FLG_TICK];
   endproperty
   a_tick_flag: assert property (p_tick_flag) else $error("tick flag not set");

   property p_alarm;
      alarm_ev |=> flags_q[`RTCCA_FLG_ALARM] ##0 (wake_o == !$past(pins_q.sys_on));
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm event mishandled");

   property p_off;
      clock_off_bit_q |-> !tick ##1 $stable(seconds_in_day_counter_q) || $past(wr);
   endproperty
   a_off: assert property (p_off) else $error("clock ran while off");

   property p_div_tc;
      tick |-> div_cnt_q == term_cnt ##1 div_cnt_q == 17'h00000;
   endproperty
   a_div_tc: assert property (p_div_tc) else $error("divider terminal wrong");

   property p_uv;
      pins_q.uv |-> !charge_o.cur_high && !charge_o.cur_low;
   endproperty
   a_uv: assert property (p_uv) else $error("charging below undervoltage");

   property p_set_wins;
      tick && flags_clr[`RTCCA_FLG_TICK] |=> flags_q[`RTCCA_FLG_TICK];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost in clear");

   property p_chg_kept;
      backup_charge_on_q && !(wr && ofs == `RTCCA_OFS_CHG) |=> backup_charge_on_q;
   endproperty
   a_chg_kept: assert property (p_chg_kept) else $error("charger enable dropped");

   property p_unmask;
      pins_q.sys_on && flags_q[`RTCCA_FLG_LOST] && !mask_q[`RTCCA_FLG_LOST] |-> irq_o;
   endproperty
   a_unmask: assert property (p_unmask) else $error("unmasked flag no interrupt");

   c_wrap: cover property (tick && seconds_in_day_counter_q == `RTCCA_SEC_MAX);
   c_alarm: cover property (alarm_ev);
   c_trim: cover property (tick && trim_on && drift_trim_word_q != 5'h00);

endmodule // rtcca_top

// ---- test/rtcca_host_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// host processor model: classic wishbone master
// ----------------------------------------------------------------
module rtcca_host_model (
   // clock
   input wire logic clk_i,
   // bus toward the block
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [31:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o,
   // answer from the block
   input wire logic ack_i,
   input wire logic [31:0] dat_i
);
   // idle bus from time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 32'h00000000;
      sel_o = 4'h0;
      dat_o = 32'h00000000;
   end

   // one access; request held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= {24'h000000, a};
      sel_o <= 4'hF;
      dat_o <= d;
      @(posedge clk_i);
      while (ack_i !== 1'b1) @(posedge clk_i);
      // read data is taken at the ack edge only
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
   endtask
endmodule // rtcca_host_model

// ---- test/tb_rtcca_top.sv ----
`timescale 1ns/1ps
`include "rtcca_params.svh"

// ----------------------------------------------------------------
// testbench for the clock block
// ----------------------------------------------------------------
module tb_rtcca_top;
   logic clk_i = 1'b0; // 20 MHz
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, irq_o, wake_o, slow_o;
   logic [31:0] adr, wdat, rdat;
   logic [3:0] sel;
   logic osc_i = 1'b0, osc_run = 1'b0, sys_on = 1'b0, coin = 1'b0, uv = 1'b0;
   rtcca_pkg::rtcca_chg_t chg;
   integer seed = 32'h80c4b5cc; // fixed seed
   integer n_errors = 0, checked = 0, cycles = 0, n, i, osc_r = 0, slow_r = 0;
   logic osc_p = 1'b0, slow_p = 1'b0;
   logic [31:0] d;
   logic [7:0] a;
   logic [2:0] lvl;

   always #25 clk_i = ~clk_i;

   rtcca_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .osc_i(osc_i), .sys_on_i(sys_on), .coin_only_i(coin),
      .undervoltage_limit_i(uv), .irq_o(irq_o), .wake_o(wake_o),
      .slow_clock_out_o(slow_o), .charge_o(chg));

   rtcca_host_model host_u (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(wdat), .ack_i(ack), .dat_i(rdat));

   // ----------------------------------------------------------------
   // oscillator stand-in, edge counters and hang guard
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (osc_run) osc_i <= ~osc_i; // fast stand-in keeps one second short
      osc_p <= osc_i;
      slow_p <= slow_o;
      if (osc_i && !osc_p) osc_r = osc_r + 1;
      if (slow_o === 1'b1 && slow_p === 1'b0) slow_r = slow_r + 1;
      cycles = cycles + 1;
      if (cycles == 80000) begin
         n_errors = n_errors + 1; // run took too long
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // checking and bus helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
      logic [31:0] q;
      host_u.xfer(1'b1, ad, dt, q);
   endtask

   task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] exp);
      logic [31:0] q;
      host_u.xfer(1'b0, ad, 32'h00000000, q);
      chk(nm, q, exp);
   endtask

   // readback of a counter or alarm register keeps only its width
   function automatic logic [31:0] exp_rw(input logic [7:0] ad, input logic [31:0] dt);
      return (ad == `RTCCA_OFS_SEC || ad == `RTCCA_OFS_ASEC) ?
         {15'h0000, dt[16:0]} : {17'h00000, dt[14:0]};
   endfunction

   // cycles per second with the stand-in oscillator rising every 2 clocks
   // nominal second is 32768 oscillator edges, moved by the signed trim
   function automatic integer tick_len(input integer trim);
      return 2 * (32768 + trim);
   endfunction

   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset state
      rdc("sec_rst", `RTCCA_OFS_SEC, 32'h0);
      rdc("ctrl_rst", `RTCCA_OFS_CTRL, 32'h0);
      rdc("flag_rst", `RTCCA_OFS_FLAG, 32'h4);
      rdc("mask_rst", `RTCCA_OFS_MASK, 32'h7);
      rdc("unmapped", 8'h40, 32'h0);
      @(negedge clk_i);
      chk("irq_rst", irq_o, 32'h0);
      chk("conn_rst", chg.connect, 32'h0);
      // random values through the time and alarm registers
      for (i = 0; i < 8; i = i + 1) begin
         a = 8'(4 * (i % 4));
         d = $random(seed);
         wr(a, d);
         rdc("rw", a, exp_rw(a, d));
      end
      // pending lost flag shows once unmasked, clears on write one
      sys_on <= 1'b1;
      wr(`RTCCA_OFS_MASK, 32'h3);
      @(negedge clk_i);
      chk("irq_unmask", irq_o, 32'h1);
      wr(`RTCCA_OFS_FLAG, 32'h4);
      rdc("flag_clr", `RTCCA_OFS_FLAG, 32'h0);
      chk("irq_clr", irq_o, 32'h0);
      // charger in on, off and undervoltage
      lvl = $random(seed);
      wr(`RTCCA_OFS_CHG, {28'h0000000, lvl, 1'b1});
      @(negedge clk_i);
      chk("chg_on", chg, {25'h0, 2'h3, lvl, 2'h2});
      @(posedge clk_i) sys_on <= 1'b0;
      repeat (5) @(posedge clk_i);
      chk("chg_off", chg, {25'h0, 2'h3, lvl, 2'h1});
      uv <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk("chg_uv", chg, {25'h0, 2'h2, lvl, 2'h0});
      uv <= 1'b0;
      rdc("chg_keep", `RTCCA_OFS_CHG, {27'h0, 1'b1, lvl, 1'b1});
      // one trimmed second across the day boundary, alarm at day 6 second 0
      wr(`RTCCA_OFS_ASEC, 32'h0);
      wr(`RTCCA_OFS_ADAY, 32'h6);
      wr(`RTCCA_OFS_SEC, 32'h0001517F);
      wr(`RTCCA_OFS_DAY, 32'h5);
      wr(`RTCCA_OFS_MASK, 32'h0);
      wr(`RTCCA_OFS_CTRL, 32'h1); // clock off holds the divider at zero
      osc_run <= 1'b1;
      repeat (8) @(posedge clk_i);
      wr(`RTCCA_OFS_CTRL, 32'h106);
      n = 0;
      while (wake_o !== 1'b1 && n < 70000) begin
         @(posedge clk_i);
         n = n + 1;
      end
      chk("period", (n >= tick_len(-16) - 6 && n <= tick_len(-16) + 12), 32'h1);
      chk("slow_clk", (osc_r - slow_r >= 0 && osc_r - slow_r <= 2), 32'h1);
      @(negedge clk_i);
      chk("irq_sys_off", irq_o, 32'h0);
      chk("wake_once", wake_o, 32'h0);
      rdc("sec_wrap", `RTCCA_OFS_SEC, 32'h0);
      rdc("day_inc", `RTCCA_OFS_DAY, 32'h6);
      rdc("flag_evt", `RTCCA_OFS_FLAG, 32'h3);
      @(posedge clk_i) sys_on <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk("irq_sys_on", irq_o, 32'h1);
      wr(`RTCCA_OFS_FLAG, 32'h3);
      @(negedge clk_i);
      chk("irq_done", irq_o, 32'h0);
      // backup-domain reset in mid-run
      @(posedge clk_i) rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc("sec_por", `RTCCA_OFS_SEC, 32'h0);
      rdc("aday_por", `RTCCA_OFS_ADAY, 32'h0);
      // system still on, so the cell joins again right after the reset
      rdc("chg_por", `RTCCA_OFS_CHG, 32'h10);
      rdc("flag_por", `RTCCA_OFS_FLAG, 32'h4);
      summarize();
   end
endmodule // tb_rtcca_top
